// ===== logic/sdat_pkg.sv
// shared types and constants for the vector duplicate / add-sub / truncate unit
// assumes the decoder fills a request struct and takes a result struct on the core clock
package sdat_pkg;

	// operations carried out by the unit
	typedef enum logic [2:0] {
		op_truncating_int_store_pop   = 3'h0,
		op_split_free_unaligned_load  = 3'h1,
		op_odd_lane_duplicate_move    = 3'h2,
		op_even_lane_duplicate_move   = 3'h3,
		op_double_element_duplicate_move = 3'h4,
		op_single_alternating_add_sub = 3'h5,
		op_double_alternating_add_sub = 3'h6
	} sdat_op_e;

	// destination integer width of the truncating store
	typedef enum logic [1:0] {iw_word = 2'h0, iw_dword = 2'h1, iw_qword = 2'h2} sdat_iw_e;

	// processor operating mode
	typedef enum logic [1:0] {mode_protected = 2'h0, mode_compat = 2'h1, mode_64bit = 2'h2} sdat_mode_e;

	// memory sequencing states
	typedef enum logic {st_idle = 1'b0, st_mem_wait = 1'b1} sdat_state_e;

	// rounding control codes
	localparam logic [1:0] RC_NEAR = 2'h0;
	localparam logic [1:0] RC_DOWN = 2'h1;
	localparam logic [1:0] RC_UP   = 2'h2;
	localparam logic [1:0] RC_ZERO = 2'h3;

	// field positions in the vector control/status word and the stack control word
	localparam int VCS_MASK_LSB = 7;
	localparam int VCS_RC_LSB   = 13;
	localparam int FCW_IM_BIT   = 0;
	localparam int FCW_PM_BIT   = 5;

	// exception flag positions
	localparam int EXC_IE = 0;
	localparam int EXC_OE = 3;
	localparam int EXC_UE = 4;
	localparam int EXC_PE = 5;

	// number formats
	localparam logic [14:0] EXT_EXP_MAX   = 15'h7FFF;
	localparam logic [14:0] EXT_INT_SHIFT = 15'h403E;
	localparam logic [11:0] EMAX_DBL      = 12'h7FF;
	localparam logic [11:0] EMAX_SGL      = 12'h0FF;
	localparam logic [63:0] QNAN_DBL      = 64'hFFF8_0000_0000_0000;
	localparam logic [63:0] QNAN_SGL      = 64'h0000_0000_FFC0_0000;

	// memory geometry
	localparam int ALIGN_LSB  = 4;
	localparam int MEM_DATA_W = 256;

	// one request from the decoder
	typedef struct packed {
		sdat_op_e    op;
		sdat_iw_e    iw;
		logic [127:0] a;
		logic [127:0] b;
		logic [79:0] fp_top;
		logic [63:0] addr;
		logic [2:0]  dst_reg;
		logic        ext_r;
		logic        ext_w;
	} sdat_req_s;

	// one result to the register file
	typedef struct packed {
		logic [127:0] vec;
		logic [63:0] int_val;
		sdat_iw_e    iw;
		logic [3:0]  dst_idx;
		logic        vec_we;
		logic        int_we;
		logic        pop;
		logic [5:0]  exc;
		logic        fault;
	} sdat_res_s;

endpackage : sdat_pkg

// ===== logic/sdat_unit.sv
// execution datapath: truncating store, split-free load, lane duplicates, add/sub
// assumes decoder and register file on clk_sys_i; memory answers on the same clock
//
// Overview of operation
// [RULE1] truncating store: chop toward zero, then pop
// [RULE2] store widths: 16, 32 and 64 bits
// [RULE3] control word only unmasks invalid/inexact faults
// [RULE4] aligned split-free load fetches sixteen bytes
// [RULE5] misaligned: fetch 32 bytes below, extract sixteen
// [RULE6] odd duplicate: lanes 3,3,1,1 of source
// [RULE7] even duplicate: lanes 2,2,0,0 of source
// [RULE8] double duplicate: 64-bit source into both halves
// [RULE9] single add/sub: even lanes subtract, odd add
// [RULE10] double add/sub: lane0 subtract, lane1 add
// [RULE11] 64-bit mode: extension bit reaches registers 8-15
// [RULE12] width bit selects wide registers; else ignored (the unit never reads ext_w; registers 8-15 come from ext_r alone)
// [RULE13] compatibility mode behaves as protected mode
// [RULE14] no architectural state; save/restore unchanged
// [RULE15] vector ops use vector control/status word
// [RULE16] lane 0 sits in least significant bits
`timescale 1ns/100ps

module sdat_unit (
	// clock, reset, enable
	input  wire logic            clk_sys_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	// request from decoder
	input  wire logic            req_valid_i,
	input  wire sdat_pkg::sdat_req_s req_i,
	output logic                 req_ready_o,
	// control inputs
	input  wire sdat_pkg::sdat_mode_e mode_i,
	input  wire logic [31:0]     vcs_i,
	input  wire logic [15:0]     fcw_i,
	// memory read port
	output logic                 mem_req_o,
	output logic [63:0]          mem_addr_o,
	output logic                 mem_wide_o,
	input  wire logic            mem_ack_i,
	input  wire logic [255:0]    mem_rdata_i,
	// result to register file
	output logic                 res_valid_o,
	output sdat_pkg::sdat_res_s  res_o
);
	import sdat_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// arithmetic functions

	// ieee add of two values of one format, single kept in the low word
	function automatic logic [67:0] fp_addsub(input logic [63:0] a, input logic [63:0] b,
		input logic sub, input logic dbl, input logic [1:0] rc);
		logic [11:0] ea, eb, e, emax, et;
		logic [52:0] fa, fb;
		logic [57:0] ma, mb, m, mt;
		logic [53:0] mr;
		logic [63:0] r;
		logic sa, sb, s, st, g, inc, inx, hid, ie, oe, ue, to_inf, ta;
		logic nan_a, nan_b, inf_a, inf_b;
		begin
			// unpack; single fraction moved up so both share one datapath
			sa = dbl ? a[63] : a[31];
			sb = (dbl ? b[63] : b[31]) ^ sub;
			ea = dbl ? {1'b0, a[62:52]} : {4'h0, a[30:23]};
			eb = dbl ? {1'b0, b[62:52]} : {4'h0, b[30:23]};
			emax = dbl ? EMAX_DBL : EMAX_SGL;
			fa = {ea != 12'h0, dbl ? a[51:0] : {a[22:0], 29'h0}};
			fb = {eb != 12'h0, dbl ? b[51:0] : {b[22:0], 29'h0}};
			nan_a = (ea == emax) && (fa[51:0] != 52'h0);
			nan_b = (eb == emax) && (fb[51:0] != 52'h0);
			inf_a = (ea == emax) && (fa[51:0] == 52'h0);
			inf_b = (eb == emax) && (fb[51:0] == 52'h0);
			ie = (nan_a && !fa[51]) || (nan_b && !fb[51]);
			if (ea == 12'h0) ea = 12'h1;
			if (eb == 12'h0) eb = 12'h1;
			ma = {2'h0, fa, 3'h0};
			mb = {2'h0, fb, 3'h0};
			// larger magnitude first
			if ({eb, mb} > {ea, ma}) begin
				et = ea; ea = eb; eb = et;
				mt = ma; ma = mb; mb = mt;
				ta = sa; sa = sb; sb = ta;
			end
			// align with sticky
			st = |(mb & ~({58{1'b1}} << (ea - eb)));
			mb = mb >> (ea - eb);
			mb[0] = mb[0] | st;
			m = (sa == sb) ? ma + mb : ma - mb;
			e = ea;
			s = sa;
			if (m == 58'h0) s = (sa == sb) ? sa : (rc == RC_DOWN);
			// normalise
			if (m[56]) begin
				st = m[0];
				m = m >> 1;
				m[0] = m[0] | st;
				e = e + 12'h1;
			end else begin
				for (int i = 0; i < 56; i++) begin
					if (!m[55] && e > 12'h1) begin
						m = m << 1;
						e = e - 12'h1;
					end
				end
			end
			// round at the format's own lsb
			g = dbl ? m[2] : m[31];
			st = dbl ? |m[1:0] : |m[30:0];
			mr = dbl ? {1'b0, m[55:3]} : {30'h0, m[55:32]};
			inx = g | st;
			case (rc)
				RC_NEAR: inc = g & (st | mr[0]);
				RC_DOWN: inc = inx & s;
				RC_UP:   inc = inx & !s;
				default: inc = 1'b0;
			endcase
			mr = mr + {53'h0, inc};
			if (dbl ? mr[53] : mr[24]) begin
				mr = mr >> 1;
				e = e + 12'h1;
			end
			hid = dbl ? mr[52] : mr[23];
			ue = inx && !hid;
			oe = e >= emax;
			to_inf = (rc == RC_NEAR) || (rc == RC_UP && !s) || (rc == RC_DOWN && s);
			// overflow: infinity or largest finite by direction
			if (oe) begin
				inx = 1'b1;
				e = to_inf ? emax : emax - 12'h1;
				mr = to_inf ? 54'h0 : {54{1'b1}};
			end
			if (!hid && !oe) e = 12'h0;
			r = dbl ? {s, e[10:0], mr[51:0]} : {32'h0, s, e[7:0], mr[22:0]};
			// special operands override
			if (nan_a || nan_b) begin
				r = nan_a ? a : b;
				if (dbl) r[51] = 1'b1;
				else r[22] = 1'b1;
				{oe, ue, inx} = 3'h0;
			end else if (inf_a && inf_b && (sa != sb)) begin
				r = dbl ? QNAN_DBL : QNAN_SGL;
				ie = 1'b1;
				{oe, ue, inx} = 3'h0;
			end else if (inf_a || inf_b) begin
				r = dbl ? {sa, 11'h7FF, 52'h0} : {32'h0, sa, 8'hFF, 23'h0};
				{oe, ue, inx} = 3'h0;
			end
			fp_addsub = {ie, oe, ue, inx, r};
		end
	endfunction : fp_addsub

	// extended value to integer by chopping, range-checked for the width
	function automatic logic [65:0] trunc_to_int(input logic [79:0] x, input sdat_iw_e iw);
		logic [14:0] sh;
		logic [127:0] wide;
		logic [63:0] mag, lim, val;
		logic ie, pe;
		begin
			sh = EXT_INT_SHIFT - x[78:64];
			wide = {x[63:0], 64'h0} >> sh;
			mag = wide[127:64];
			pe = (sh >= 15'h040) ? |x[63:0] : |wide[63:0];
			unique case (iw)
				iw_word:  lim = 64'h0000_0000_0000_8000;
				iw_dword: lim = 64'h0000_0000_8000_0000;
				iw_qword: lim = 64'h8000_0000_0000_0000;
				default:  lim = 64'h0000_0000_0000_8000;
			endcase
			ie = (x[78:64] == EXT_EXP_MAX) || (x[78:64] > EXT_INT_SHIFT) ||
				(x[79] ? mag > lim : mag >= lim);
			val = (x[79] ? -mag : mag) & ((lim << 1) - 64'h1);
			if (ie) begin
				val = lim;
				pe = 1'b0;
			end
			trunc_to_int = {ie, pe, val};
		end
	endfunction : trunc_to_int

	// map adder flags onto the six-bit exception vector
	function automatic logic [5:0] exc_of(input logic [3:0] f);
		logic [5:0] x;
		begin
			x = 6'h0;
			x[EXC_IE] = f[3];
			x[EXC_OE] = f[2];
			x[EXC_UE] = f[1];
			x[EXC_PE] = f[0];
			exc_of = x;
		end
	endfunction : exc_of

	////////////////////////////////////////////////////////////////////////////
	// declarations

	sdat_state_e  state;          // memory sequencer state
	sdat_state_e  next_state;     // its next value
	logic         take;           // request accepted this cycle
	logic         load_done;      // memory answer arrives
	logic [1:0]   vrc;            // vector rounding control
	logic [5:0]   vmask;          // vector exception masks
	logic [67:0]  sgl_lane [4];   // single lanes: flags and value
	logic [67:0]  dbl_lane [2];   // double lanes: flags and value
	logic [65:0]  trunc_res;      // truncation: flags and value
	logic [3:0]   dst_idx;        // decoded destination register
	logic [3:0]   off_q;          // byte offset of pending load
	logic [3:0]   load_dst_q;     // destination of pending load
	logic [255:0] shifted;        // fetched block moved to the requested byte
	sdat_res_s    next_res;       // result of a single-cycle operation
	sdat_res_s    next_load;      // result of a finished load
	sdat_res_s    res_q;          // registered result
	logic         res_valid_q;    // registered result strobe
	logic         mem_req_q;      // memory request level
	logic [63:0]  mem_addr_q;     // aligned fetch address
	logic         mem_wide_q;     // two-line fetch

	////////////////////////////////////////////////////////////////////////////
	// control and lanes

	assign req_ready_o = (state == st_idle);
	assign take        = req_valid_i && req_ready_o;
	assign load_done   = (state == st_mem_wait) && mem_ack_i;
	assign vrc         = vcs_i[VCS_RC_LSB +: 2];     // RULE15
	assign vmask       = vcs_i[VCS_MASK_LSB +: 6];   // RULE15
	assign trunc_res   = trunc_to_int(req_i.fp_top, req_i.iw); // RULE1 RULE2

	// extension bit only counts in 64-bit mode; compatibility treated as protected
	assign dst_idx = {req_i.ext_r && (mode_i == mode_64bit), req_i.dst_reg}; // RULE11 RULE13

	// single lanes: even lanes subtract, odd lanes add
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sgl
			assign sgl_lane[gi] = fp_addsub({32'h0, req_i.a[gi*32 +: 32]},
				{32'h0, req_i.b[gi*32 +: 32]}, (gi % 2) == 0, 1'b0, vrc); // RULE9 RULE16
		end
		// double lanes: lane 0 subtracts, lane 1 adds
		for (gi = 0; gi < 2; gi++) begin : g_dbl
			assign dbl_lane[gi] = fp_addsub(req_i.a[gi*64 +: 64], req_i.b[gi*64 +: 64],
				gi == 0, 1'b1, vrc); // RULE10 RULE16
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// single-cycle results

	// the width bit has no meaning in this unit and is dropped without fault
	always_comb begin
		next_res = '0;
		next_res.iw = req_i.iw;
		next_res.dst_idx = dst_idx; // RULE12
		unique case (req_i.op)
			op_truncating_int_store_pop: begin
				// stack rounding field never read; only two masks matter
				next_res.int_val = trunc_res[63:0]; // RULE1
				next_res.exc[EXC_IE] = trunc_res[65];
				next_res.exc[EXC_PE] = trunc_res[64];
				next_res.fault = (trunc_res[65] && !fcw_i[FCW_IM_BIT]) ||
					(trunc_res[64] && !fcw_i[FCW_PM_BIT]); // RULE3
				next_res.int_we = !next_res.fault;
				next_res.pop = !next_res.fault; // RULE1
			end
			op_odd_lane_duplicate_move: begin
				next_res.vec = {req_i.b[127:96], req_i.b[127:96],
					req_i.b[63:32], req_i.b[63:32]}; // RULE6
				next_res.vec_we = 1'b1;
			end
			op_even_lane_duplicate_move: begin
				next_res.vec = {req_i.b[95:64], req_i.b[95:64],
					req_i.b[31:0], req_i.b[31:0]}; // RULE7
				next_res.vec_we = 1'b1;
			end
			op_double_element_duplicate_move: begin
				next_res.vec = {req_i.b[63:0], req_i.b[63:0]}; // RULE8
				next_res.vec_we = 1'b1;
			end
			op_single_alternating_add_sub: begin
				next_res.vec = {sgl_lane[3][31:0], sgl_lane[2][31:0],
					sgl_lane[1][31:0], sgl_lane[0][31:0]}; // RULE9
				next_res.exc = exc_of(sgl_lane[0][67:64] | sgl_lane[1][67:64] |
					sgl_lane[2][67:64] | sgl_lane[3][67:64]);
				next_res.fault = |(next_res.exc & ~vmask); // RULE15
				next_res.vec_we = !next_res.fault;
			end
			op_double_alternating_add_sub: begin
				next_res.vec = {dbl_lane[1][63:0], dbl_lane[0][63:0]}; // RULE10
				next_res.exc = exc_of(dbl_lane[0][67:64] | dbl_lane[1][67:64]);
				next_res.fault = |(next_res.exc & ~vmask); // RULE15
				next_res.vec_we = !next_res.fault;
			end
			default: begin
				// load finishes later; illegal codes write nothing
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// split-free load

	// move the fetched block down so the requested byte lands in lane 0
	assign shifted = mem_rdata_i >> {off_q, 3'h0}; // RULE5 RULE16

	// finished load result
	always_comb begin
		next_load = '0;
		next_load.vec = shifted[127:0]; // RULE4 RULE5
		next_load.dst_idx = load_dst_q;
		next_load.vec_we = 1'b1;
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle:
				if (take && req_i.op == op_split_free_unaligned_load) next_state = st_mem_wait;
			st_mem_wait:
				if (mem_ack_i) next_state = st_idle;
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= st_idle;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// fetch request: aligned address, one or two lines
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mem_req_q  <= 1'b0;
			mem_addr_q <= 64'h0;
			mem_wide_q <= 1'b0;
			off_q      <= 4'h0;
			load_dst_q <= 4'h0;
		end else if (ce_i) begin
			if (take && req_i.op == op_split_free_unaligned_load) begin
				mem_req_q  <= 1'b1;
				mem_addr_q <= {req_i.addr[63:ALIGN_LSB], 4'h0}; // RULE5
				mem_wide_q <= req_i.addr[ALIGN_LSB-1:0] != 4'h0; // RULE4 RULE5
				off_q      <= req_i.addr[ALIGN_LSB-1:0];
				load_dst_q <= dst_idx; // RULE11
			end else if (load_done) begin
				mem_req_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result register

	// pipeline register only; nothing here outlives the operation
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			res_valid_q <= 1'b0;
			res_q       <= '0;
		end else if (ce_i) begin
			res_valid_q <= load_done || (take && req_i.op != op_split_free_unaligned_load);
			if (load_done) begin
				res_q <= next_load;
			end else if (take) begin
				res_q <= next_res; // RULE14
			end
		end
	end

	assign res_valid_o = res_valid_q;
	assign res_o       = res_q;
	assign mem_req_o   = mem_req_q;
	assign mem_addr_o  = mem_addr_q;
	assign mem_wide_o  = mem_wide_q;

endmodule : sdat_unit

// ===== tb/sdat_unit_asserts.sv
// checker: timing and lane relations seen at the ports of the unit
// assumes it is bound onto sdat_unit; one core clock, async active-high reset
`timescale 1ns/100ps

module sdat_unit_asserts (
	// clock, reset, enable
	input wire logic                 clk_sys_i,
	input wire logic                 rst_i,
	input wire logic                 ce_i,
	// request side
	input wire logic                 req_valid_i,
	input wire sdat_pkg::sdat_req_s  req_i,
	input wire logic                 req_ready_o,
	input wire sdat_pkg::sdat_mode_e mode_i,
	input wire logic [31:0]          vcs_i,
	input wire logic [15:0]          fcw_i,
	// memory port
	input wire logic                 mem_req_o,
	input wire logic [63:0]          mem_addr_o,
	input wire logic                 mem_wide_o,
	input wire logic                 mem_ack_i,
	input wire logic [255:0]         mem_rdata_i,
	// result side
	input wire logic                 res_valid_o,
	input wire sdat_pkg::sdat_res_s  res_o
);
	import sdat_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	logic      take;   // request taken at this edge
	logic      take_q; // a request was taken at the last enabled edge
	sdat_req_s req_q;  // copy of the request at the last enabled edge, taken or not
	logic [3:0] idx_q; // destination index owed to that request
	assign take = ce_i && req_valid_i && req_ready_o;

	// remember the taken request so results can be tied to it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			take_q <= 1'b0;
			req_q <= '0;
			idx_q <= 4'h0;
		end else if (ce_i) begin
			take_q <= take;
			req_q <= req_i;
			idx_q <= {req_i.ext_r && (mode_i == mode_64bit), req_i.dst_reg};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_load_refused: assert property (mem_req_o |-> !req_ready_o)
		else $error("request accepted while a fetch waits");
	a_fetch_base: assert property (take && req_i.op == op_split_free_unaligned_load |=>
		mem_req_o && mem_addr_o == {req_q.addr[63:4], 4'h0})
		else $error("fetch address not the aligned base");
	a_fetch_width: assert property (take && req_i.op == op_split_free_unaligned_load |=>
		mem_wide_o == (req_q.addr[3:0] != 4'h0))
		else $error("fetch width wrong for the offset");
	a_fetch_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("fetch dropped or moved before answer");
	a_ack_result: assert property (ce_i && mem_req_o && mem_ack_i |=>
		!mem_req_o && res_valid_o && res_o.vec_we)
		else $error("no load result after the answer");
	a_op_latency: assert property (take && req_i.op != op_split_free_unaligned_load |=>
		res_valid_o)
		else $error("result missing one cycle after request");
	a_odd_dup: assert property (take_q && req_q.op == op_odd_lane_duplicate_move |-> res_o.vec ==
		{req_q.b[127:96], req_q.b[127:96], req_q.b[63:32], req_q.b[63:32]})
		else $error("odd duplicate lanes wrong");
	a_even_dup: assert property (take_q && req_q.op == op_even_lane_duplicate_move |-> res_o.vec ==
		{req_q.b[95:64], req_q.b[95:64], req_q.b[31:0], req_q.b[31:0]})
		else $error("even duplicate lanes wrong");
	a_double_dup: assert property (take_q && req_q.op == op_double_element_duplicate_move |->
		res_o.vec == {req_q.b[63:0], req_q.b[63:0]})
		else $error("double duplicate halves wrong");
	a_store_pop: assert property (take_q && req_q.op == op_truncating_int_store_pop |->
		res_o.pop == !res_o.fault && res_o.int_we == !res_o.fault)
		else $error("store pop or write wrong");
	a_dest_index: assert property (take_q && req_q.op != op_split_free_unaligned_load |->
		res_o.dst_idx == idx_q)
		else $error("destination index wrong");
endmodule : sdat_unit_asserts

// ===== tb/sdat_mem_model.sv
// memory model on the fetch port: answers after a wait of 0 to 3 cycles
// assumes the unit holds its fetch until it sees the one-cycle answer
`timescale 1ns/100ps

module sdat_mem_model (
	// clock, reset, enable
	input wire logic      clk_sys_i,
	input wire logic      rst_i,
	input wire logic      ce_i,
	// fetch from the unit
	input wire logic      mem_req_i,
	input wire logic [63:0] mem_addr_i,
	input wire logic      mem_wide_i,
	// answer to the unit
	output logic          mem_ack_o,
	output logic [255:0]  mem_rdata_o
);
	logic [1:0] wait_cnt; // cycles left before answering
	logic       busy;     // a fetch is being served
	logic       fire;     // answer goes out at this edge
	assign fire = busy && wait_cnt == 2'h0 && !mem_ack_o;

	// handshake: wait taken from the address so waits vary
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mem_ack_o <= 1'b0;
			busy <= 1'b0;
			wait_cnt <= 2'h0;
		end else if (!ce_i) begin
			// frozen together with the unit while the enable is low
		end else if (mem_ack_o) begin
			mem_ack_o <= 1'b0;
			busy <= 1'b0;
		end else if (mem_req_i && !busy) begin
			busy <= 1'b1;
			wait_cnt <= mem_addr_i[5:4];
		end else if (busy && wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
		end else if (busy) begin
			mem_ack_o <= 1'b1;
		end
	end

	// data: byte k holds its address xor A5; bytes not fetched keep toggling
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mem_rdata_o <= '0;
		end else if (ce_i) begin
			for (int k = 0; k < 32; k++) begin
				if (fire && (mem_wide_i || k < 16)) begin
					mem_rdata_o[8*k+:8] <= (mem_addr_i[7:0] + 8'(k)) ^ 8'hA5;
				end else begin
					mem_rdata_o[8*k+:8] <= ~mem_rdata_o[8*k+:8];
				end
			end
		end
	end
endmodule : sdat_mem_model

// ===== tb/test_simd_dup_addsub_trunc_unit.sv
// self-checking bench for the vector duplicate / add-sub / truncate unit
// assumes the memory model on the fetch port and the checker bound to the unit
`timescale 1ns/100ps

module test_simd_dup_addsub_trunc_unit;
	import sdat_pkg::*;
	logic       clk_sys_i, rst_i, ce_i, req_valid_i, req_ready_o, res_valid_o;
	logic       mem_req_o, mem_wide_o, mem_ack_i;
	sdat_req_s  req_i;
	sdat_mode_e mode_i;
	logic [31:0] vcs_i;
	logic [15:0] fcw_i;
	logic [63:0] mem_addr_o;
	logic [255:0] mem_rdata_i;
	sdat_res_s  res_o;
	sdat_res_s  exp_q[$]; // expected results in issue order
	int         n_mismatch, checks_done, seed;

	sdat_unit u_sdat_unit (.clk_sys_i, .rst_i, .ce_i, .req_valid_i, .req_i, .req_ready_o,
		.mode_i, .vcs_i, .fcw_i, .mem_req_o, .mem_addr_o, .mem_wide_o, .mem_ack_i,
		.mem_rdata_i, .res_valid_o, .res_o);
	sdat_mem_model u_sdat_mem_model (.clk_sys_i, .rst_i, .ce_i, .mem_req_i(mem_req_o),
		.mem_addr_i(mem_addr_o), .mem_wide_i(mem_wide_o), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// random enable gaps; unit and memory model freeze together
	always @(posedge clk_sys_i) ce_i <= rst_i || ($random(seed) % 4 != 0);

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// issue one request with random destination and mode; note what it owes
	// fl packs {vec_we, int_we, pop, fault, inexact}
	task automatic go(input sdat_op_e op, input sdat_iw_e iw, input logic [127:0] a,
		input logic [127:0] b, input logic [79:0] fp, input logic [63:0] addr,
		input logic [127:0] ev, input logic [63:0] ei, input logic [4:0] fl);
		sdat_req_s  r;
		sdat_res_s  e;
		sdat_mode_e m;
		r = '0;
		e = '0;
		m = sdat_mode_e'(2'({$random(seed)} % 3));
		r.op = op;
		r.iw = iw;
		r.a = a;
		r.b = b;
		r.fp_top = fp;
		r.addr = addr;
		r.dst_reg = 3'($random(seed));
		r.ext_r = 1'($random(seed));
		r.ext_w = 1'($random(seed));
		e.vec = ev;
		e.int_val = ei;
		{e.vec_we, e.int_we, e.pop, e.fault, e.exc[EXC_PE]} = fl;
		e.dst_idx = {r.ext_r && m == mode_64bit, r.dst_reg};
		mode_i <= m;
		req_valid_i <= 1'b1;
		req_i <= r;
		exp_q.push_back(e);
		@(negedge clk_sys_i);
		while (req_ready_o !== 1'b1 || ce_i !== 1'b1) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
	endtask : go

	// results are settled at the falling edge; compare with the oldest note
	always @(negedge clk_sys_i) begin
		sdat_res_s e;
		if (res_valid_o === 1'b1 && ce_i === 1'b1) begin
			e = exp_q.pop_front();
			check("write enables", {res_o.vec_we, res_o.int_we}, {e.vec_we, e.int_we});
			check("pop", res_o.pop, e.pop);
			check("fault", res_o.fault, e.fault);
			check("inexact", res_o.exc[EXC_PE], e.exc[EXC_PE]);
			check("dst_idx", res_o.dst_idx, e.dst_idx);
			if (e.vec_we) check("vec", res_o.vec, e.vec);
			if (e.int_we) check("int_val", res_o.int_val, e.int_val);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [127:0] b, ev;
		logic [63:0]  addr, iv;
		seed = 73421;
		n_mismatch = 0;
		checks_done = 0;
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_i = '0;
		mode_i = mode_protected;
		vcs_i = 32'h0000_1F80;
		fcw_i = 16'h003F;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		// lane duplicates back to back on random sources
		for (int i = 0; i < 9; i++) begin
			b = {$random(seed), $random(seed), $random(seed), $random(seed)};
			case (i % 3)
				0: go(op_odd_lane_duplicate_move, iw_word, ~b, b, '0, '0,
					{b[127:96], b[127:96], b[63:32], b[63:32]}, '0, 5'h10);
				1: go(op_even_lane_duplicate_move, iw_word, ~b, b, '0, '0,
					{b[95:64], b[95:64], b[31:0], b[31:0]}, '0, 5'h10);
				default: go(op_double_element_duplicate_move, iw_word, ~b, b, '0, '0,
					{b[63:0], b[63:0]}, '0, 5'h10);
			endcase
		end
		// truncating store of +-2.75, rounding control set to mislead
		for (int i = 0; i < 6; i++) begin
			fcw_i <= i[0] ? 16'h0421 : 16'h0821;
			iv = i[0] ? 64'hFFFF_FFFF_FFFF_FFFE : 64'h2;
			iv = (i < 2) ? {48'h0, iv[15:0]} : (i < 4) ? {32'h0, iv[31:0]} : iv;
			go(op_truncating_int_store_pop, sdat_iw_e'(2'(i / 2)), '0, '0,
				{i[0], 15'h4000, 64'hB000_0000_0000_0000}, '0, '0, iv, 5'h0D);
		end
		// inexact unmasked faults; exact value with all unmasked does not
		fcw_i <= 16'h0801;
		go(op_truncating_int_store_pop, iw_dword, '0, '0,
			{1'b0, 15'h4000, 64'hB000_0000_0000_0000}, '0, '0, '0, 5'h03);
		fcw_i <= 16'h0800;
		go(op_truncating_int_store_pop, iw_word, '0, '0,
			{1'b0, 15'h4000, 64'h8000_0000_0000_0000}, '0, '0, 64'h2, 5'h0C);
		// out of range: indefinite when invalid is masked, fault when not
		for (int i = 0; i < 2; i++) begin
			fcw_i <= i[0] ? 16'h0020 : 16'h0021;
			go(op_truncating_int_store_pop, iw_word, '0, '0,
				{1'b0, 15'h400F, 64'h8000_0000_0000_0000}, '0, '0, 64'h8000,
				i[0] ? 5'h02 : 5'h0C);
		end
		// alternating add/sub with the stack word fully unmasked
		fcw_i <= 16'h0000;
		go(op_single_alternating_add_sub, iw_word,
			{32'h4100_0000, 32'h4080_0000, 32'h4000_0000, 32'h4000_0000}, {4{32'h3F80_0000}},
			'0, '0, {32'h4110_0000, 32'h4040_0000, 32'h4040_0000, 32'h3F80_0000},
			'0, 5'h10);
		go(op_double_alternating_add_sub, iw_word, {64'h4010_0000_0000_0000,
			64'h4000_0000_0000_0000}, {2{64'h3FF0_0000_0000_0000}}, '0, '0,
			{64'h4014_0000_0000_0000, 64'h3FF0_0000_0000_0000}, '0, 5'h10);
		// inexact unmasked in the vector word faults though the stack word masks all
		vcs_i <= 32'h0000_0F80;
		fcw_i <= 16'h003F;
		go(op_single_alternating_add_sub, iw_word, {4{32'h3F80_0000}}, {4{32'h3300_0000}},
			'0, '0, '0, '0, 5'h03);
		vcs_i <= 32'h0000_1F80;
		// unused operation code: result strobe with nothing written
		go(sdat_op_e'(3'h7), iw_word, '0, '0, '0, '0, '0, '0, 5'h00);
		// split-free loads at offsets 0, 0, 6, 9, 12, 15 with varying waits
		for (int i = 0; i < 6; i++) begin
			addr = {$random(seed), $random(seed)};
			addr[3:0] = (i < 2) ? 4'h0 : 4'(i * 3);
			for (int k = 0; k < 16; k++) ev[8*k+:8] = (addr[7:0] + 8'(k)) ^ 8'hA5;
			go(op_split_free_unaligned_load, iw_word, '0, '0, '0, addr, ev, '0,
				5'h10);
		end
		req_valid_i <= 1'b0;
		repeat (30) @(posedge clk_sys_i);
		check("pending results", exp_q.size(), 0);
		finish_test();
	end

	// watchdog at 10000 cycles, far beyond the hundred or so cycles the sequence needs
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
endmodule : test_simd_dup_addsub_trunc_unit

bind sdat_unit sdat_unit_asserts u_sdat_unit_asserts (.clk_sys_i, .rst_i, .ce_i, .req_valid_i,
	.req_i, .req_ready_o, .mode_i, .vcs_i, .fcw_i, .mem_req_o, .mem_addr_o, .mem_wide_o,
	.mem_ack_i, .mem_rdata_i, .res_valid_o, .res_o);
